/* File: tcc_block.sv */
// Timer unit: 16-bit counter, four compare channels with shadow buffers,
// capture on channels 2 and 3 (first unit only), counter read buffer and output pin control.
// Assumes an APB master on ref_clk and asynchronous capture/event pins.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_block #(
    parameter bit UNIT_SECOND = 1'b0
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_2,
    input  wire logic        capture_input_3,
    input  wire logic        event_input,
    output logic      [3:0]  timer_out_pin,
    output logic      [3:0]  match_irq
);
    import tcc_pkg::*;

    tcc_pkg::ctrl_s ctrl_r;
    tcc_pkg::ioc_s  ioc_r;
    mode_e          mode;
    logic [15:0]    ccr_r    [`TCC_NCH];
    logic [15:0]    shadow_r [`TCC_NCH];
    logic [15:0]    cnt_r;
    logic [15:0]    cnt_nxt;
    logic           started_r;
    logic           armed_r;
    logic [2:0]     sy2_r, sy3_r, syev_r;
    logic [3:0]     cap_edge;
    logic [3:0]     cap_role, cmp_role, cap_ev, match, wr_ccr;
    logic           tick, ev_edge, batch, transfer, cycle_mode, out_mode;
    logic           acc, setup, wr_ok, mapped;
    logic [31:0]    rd_sel;
    logic [3:0]     out_r;

    assign mode = mode_e'(ctrl_r.mode);

    // Pins pass two flops; the third flop only feeds the edge detector
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sy2_r  <= 3'h0;
            sy3_r  <= 3'h0;
            syev_r <= 3'h0;
        end else begin
            sy2_r  <= {sy2_r[1:0], capture_input_2};
            sy3_r  <= {sy3_r[1:0], capture_input_3};
            syev_r <= {syev_r[1:0], event_input};
        end
    end
    // Rising edge is taken as the valid capture edge
    assign cap_edge = {sy3_r[1] & ~sy3_r[2], sy2_r[1] & ~sy2_r[2], 2'b00};
    assign ev_edge  = syev_r[1] & ~syev_r[2];

    // APB decode: zero wait states, read data snapshotted in the setup cycle
    assign setup  = psel & ~penable;
    assign acc    = psel & penable;
    assign pready = 1'b1;
    assign mapped = (paddr <= `TCC_OFS_CNT) && (paddr[1:0] == 2'b00);
    // Writes to the 16-bit registers without both low byte strobes are refused
    assign wr_ok  = acc & pwrite & mapped & (pstrb[1:0] == 2'b11);
    assign pslverr = acc & (~mapped | (pwrite & (pstrb[1:0] != 2'b11)
                                      | pwrite & (paddr == `TCC_OFS_CNT)));

    always_comb begin
        rd_sel = 32'h0;
        unique case (paddr)
            `TCC_OFS_CTRL: rd_sel = {25'h0, armed_r, ctrl_r};
            `TCC_OFS_IOC:  rd_sel = {24'h0, ioc_r};
            `TCC_OFS_CCR0: rd_sel = {16'h0, ccr_r[0]};
            `TCC_OFS_CCR1: rd_sel = {16'h0, ccr_r[1]};
            `TCC_OFS_CCR2: rd_sel = {16'h0, ccr_r[2]};
            `TCC_OFS_COMPARE_SHADOW_3: rd_sel = {16'h0, ccr_r[3]};
            `TCC_OFS_CNT:  rd_sel = {16'h0, ctrl_r.run ? cnt_r : `TCC_CNT_ZERO};
            default:       rd_sel = 32'h0;
        endcase
    end

    // A capture in the access cycle cannot tear the value already latched
    always_ff @(posedge ref_clk) begin
        if (reset)
            prdata <= 32'h0;
        else if (setup & ~pwrite)
            prdata <= rd_sel;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_r <= `TCC_CTRL_RST;
            ioc_r  <= `TCC_IOC_RST;
        end else if (wr_ok && paddr == `TCC_OFS_CTRL) begin
            ctrl_r <= pwdata[5:0];
        end else if (wr_ok && paddr == `TCC_OFS_IOC) begin
            ioc_r  <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            started_r <= 1'b0;
        else
            started_r <= ctrl_r.run;
    end

    assign batch      = (mode == MODE_EXT_TRIG) || (mode == MODE_PWM);
    assign cycle_mode = (mode == MODE_INTERVAL) || (mode == MODE_EVENT) || batch
                        || (mode == MODE_ONE_SHOT);
    assign tick       = (mode == MODE_EVENT) ? ev_edge : 1'b1;
    assign transfer   = batch & armed_r & match[0];
    assign out_mode   = (mode != MODE_EVENT) && (mode != MODE_PULSE_WIDTH);

    genvar i;
    generate
        for (i = 0; i < `TCC_NCH; i++) begin : g_ch
            if (i >= 2) begin : g_cap
                logic ccs;
                assign ccs = (i == 2) ? ctrl_r.ccs2 : ctrl_r.ccs3;
                assign cap_role[i] = ~UNIT_SECOND & ((mode == MODE_PULSE_WIDTH)
                                     | ((mode == MODE_FREE_RUN) & ccs));
            end else begin : g_nocap
                assign cap_role[i] = 1'b0;
            end
            assign cmp_role[i] = ~cap_role[i] & (mode != MODE_PULSE_WIDTH);
            assign cap_ev[i]   = cap_role[i] & started_r & cap_edge[i];
            assign match[i]    = cmp_role[i] & started_r & tick
                                 & (cnt_r == shadow_r[i]);
            // No compare write when the channel only captures
            assign wr_ccr[i]   = wr_ok & ~cap_role[i]
                                 & (paddr == `TCC_OFS_CCR0 + 8'(4 * i));

            always_ff @(posedge ref_clk) begin
                if (reset)
                    ccr_r[i] <= `TCC_CCR_RST;
                else if (cap_role[i] & ~ctrl_r.run)
                    ccr_r[i] <= `TCC_CCR_RST;
                else if (cap_ev[i])
                    ccr_r[i] <= cnt_r;
                else if (wr_ccr[i])
                    ccr_r[i] <= pwdata[15:0];
            end

            always_ff @(posedge ref_clk) begin
                if (reset)
                    shadow_r[i] <= `TCC_CCR_RST;
                else if (~started_r | ~batch | transfer)
                    shadow_r[i] <= ccr_r[i];
            end

            // Second unit has no channel 3 pin; it rests at its level bit
            always_ff @(posedge ref_clk) begin
                if (reset)
                    out_r[i] <= 1'b0;
                else if (~ctrl_r.run | ~ioc_r.oe[i] | ~out_mode | ~cmp_role[i]
                         | (UNIT_SECOND && i == 3))
                    out_r[i] <= ioc_r.ol[i];
                else if (~started_r)
                    out_r[i] <= ~ioc_r.ol[i];
                else if (match[i])
                    out_r[i] <= ~out_r[i];
            end
        end
    endgenerate

    assign timer_out_pin = out_r;
    assign match_irq     = match | cap_ev;

    // Arming is set by software, so a write in the transfer cycle wins
    always_ff @(posedge ref_clk) begin
        if (reset)
            armed_r <= 1'b0;
        else if (wr_ccr[1] & batch)
            armed_r <= 1'b1;
        else if (transfer | ~ctrl_r.run)
            armed_r <= 1'b0;
    end

    // Counter idles at all ones; the first wrap after start is plain counting except in event mode, where start loads zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (~ctrl_r.run)
            cnt_nxt = `TCC_CNT_IDLE;
        else if (~started_r)
            cnt_nxt = (mode == MODE_EVENT) ? `TCC_CNT_ZERO : `TCC_CNT_IDLE;
        else if (mode == MODE_PULSE_WIDTH && (cap_ev[2] | cap_ev[3]))
            cnt_nxt = `TCC_CNT_ZERO;
        else if (cycle_mode & match[0])
            cnt_nxt = `TCC_CNT_ZERO;
        else if (tick)
            cnt_nxt = cnt_r + 16'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            cnt_r <= `TCC_CNT_IDLE;
        else
            cnt_r <= cnt_nxt;
    end

    property p_cmp_keep;
        @(posedge ref_clk) disable iff (reset)
        (cmp_role[3] && $fell(ctrl_r.run)) |-> (ccr_r[3] == $past(ccr_r[3]));
    endproperty
    a_cmp_keep: assert property (p_cmp_keep) else $error("compare value lost on stop");

    property p_cap_copy;
        @(posedge ref_clk) disable iff (reset)
        (cap_ev[3] && ctrl_r.run) |=> (ccr_r[3] == $past(cnt_r));
    endproperty
    a_cap_copy: assert property (p_cap_copy) else $error("capture value wrong");

    property p_pw_clear;
        @(posedge ref_clk) disable iff (reset)
        (cap_ev[2] && ctrl_r.run && mode == MODE_PULSE_WIDTH) |=> (cnt_r == 16'h0000);
    endproperty
    a_pw_clear: assert property (p_pw_clear) else $error("counter not cleared");

    property p_cap_stop;
        @(posedge ref_clk) disable iff (reset)
        (cap_role[3] && !ctrl_r.run) ##1 cap_role[3] |-> (ccr_r[3] == 16'h0000);
    endproperty
    a_cap_stop: assert property (p_cap_stop) else $error("capture reg not cleared");

    property p_reset_val;
        @(posedge ref_clk) disable iff (reset)
        $past(reset) |-> (ccr_r[3] == 16'h0000 && !ctrl_r.run && rd_sel[15:0] != 16'hffff);
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("reset values wrong");

    property p_idle_cnt;
        @(posedge ref_clk) disable iff (reset)
        !ctrl_r.run [*2] |-> (cnt_r == 16'hffff);
    endproperty
    a_idle_cnt: assert property (p_idle_cnt) else $error("idle counter not all ones");

    property p_toggle;
        @(posedge ref_clk) disable iff (reset)
        (match[3] && ctrl_r.run && ioc_r.oe[3] && out_mode && !UNIT_SECOND)
        ##1 ctrl_r.run |-> (out_r[3] != $past(out_r[3]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not invert");

    property p_batch;
        @(posedge ref_clk) disable iff (reset)
        (batch && started_r && $past(started_r) && $stable(ctrl_r.mode)
         && shadow_r[2] != $past(shadow_r[2])) |-> $past(transfer);
    endproperty
    a_batch: assert property (p_batch) else $error("shadow moved without transfer");

    property p_low_off;
        @(posedge ref_clk) disable iff (reset)
        (!ioc_r.ol[0] && !ioc_r.oe[0]) [*2] |-> !out_r[0];
    endproperty
    a_low_off: assert property (p_low_off) else $error("disabled output not low");

    // Channel 3 is the one a bench enables; ch0 would leave this vacuous
    property p_start_lvl;
        @(posedge ref_clk) disable iff (reset)
        ($rose(started_r) && ioc_r.oe[3] && ctrl_r.run && $stable(ioc_r) && $stable(ctrl_r)
         && out_mode && cmp_role[3] && !UNIT_SECOND)
        |-> (out_r[3] == ~ioc_r.ol[3]);
    endproperty
    a_start_lvl: assert property (p_start_lvl) else $error("start level wrong");

    property p_read_latch;
        @(posedge ref_clk) disable iff (reset)
        (setup && !pwrite) |=> (prdata == $past(rd_sel));
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("read data not latched");

    property p_cnt_read;
        @(posedge ref_clk) disable iff (reset)
        (paddr == `TCC_OFS_CNT && ctrl_r.run) |-> (rd_sel[15:0] == cnt_r);
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("counter buffer not live");

    property p_cnt_zero;
        @(posedge ref_clk) disable iff (reset)
        (paddr == `TCC_OFS_CNT && !ctrl_r.run) |-> (rd_sel == 32'h0000_0000);
    endproperty
    a_cnt_zero: assert property (p_cnt_zero) else $error("stopped buffer not zero");

    property p_lvl_high;
        @(posedge ref_clk) disable iff (reset)
        (ioc_r.ol[3] && (!ioc_r.oe[3] || !ctrl_r.run)) [*2] |-> out_r[3];
    endproperty
    a_lvl_high: assert property (p_lvl_high) else $error("level one output not high");

    property p_start_cnt;
        @(posedge ref_clk) disable iff (reset)
        ($rose(started_r) && $stable(ctrl_r.mode) && mode != MODE_EVENT) |-> (cnt_r == 16'hffff);
    endproperty
    a_start_cnt: assert property (p_start_cnt) else $error("counter not started at ones");

    property p_no_pw_write;
        @(posedge ref_clk) disable iff (reset)
        (wr_ok && paddr == `TCC_OFS_COMPARE_SHADOW_3 && mode == MODE_PULSE_WIDTH && ctrl_r.run
         && !cap_ev[3] && !UNIT_SECOND) |=> (ccr_r[3] == $past(ccr_r[3]));
    endproperty
    a_no_pw_write: assert property (p_no_pw_write) else $error("capture reg written");

    property p_second_cmp;
        @(posedge ref_clk) disable iff (reset)
        UNIT_SECOND |-> !cap_role[3];
    endproperty
    a_second_cmp: assert property (p_second_cmp) else $error("second unit captures");

    property p_cap_sel;
        @(posedge ref_clk) disable iff (reset)
        (mode != MODE_FREE_RUN && mode != MODE_PULSE_WIDTH) |-> !cap_role[3];
    endproperty
    a_cap_sel: assert property (p_cap_sel) else $error("capture role in compare mode");

    property p_no_out;
        @(posedge ref_clk) disable iff (reset)
        !out_mode |=> (out_r[3] == $past(ioc_r.ol[3]));
    endproperty
    a_no_out: assert property (p_no_out) else $error("output driven in no-output mode");

endmodule : tcc_block

/* File: tcc_map.svh */
// Register offsets, field positions, reset values and counter constants
// of the timer capture/compare block. Included by the block only.
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
`define TCC_OFS_CTRL      8'h00
`define TCC_OFS_IOC       8'h04
`define TCC_OFS_CCR0      8'h08
`define TCC_OFS_CCR1      8'h0c
`define TCC_OFS_CCR2      8'h10
`define TCC_OFS_COMPARE_SHADOW_3      8'h14
`define TCC_OFS_CNT       8'h18
`define TCC_CTRL_RUN      0
`define TCC_CTRL_MODE_LO  1
`define TCC_CTRL_MODE_HI  3
`define TCC_CTRL_CCS2     4
`define TCC_CTRL_CCS3     5
`define TCC_CTRL_ARMED    6
`define TCC_IOC_OL_LO     0
`define TCC_IOC_OE_LO     4
`define TCC_CTRL_RST      6'h00
`define TCC_IOC_RST       8'h00
`define TCC_CCR_RST       16'h0000
`define TCC_CNT_IDLE      16'hffff
`define TCC_CNT_ZERO      16'h0000
`define TCC_NCH           4
`endif

/* File: tcc_pin_model.sv */
// Pin-side partner of the timer block: drives the capture and event pins.
// Assumes the bench calls pulse; the pins idle low between pulses.
`timescale 1ns/1ps
module tcc_pin_model (
    input  wire logic ref_clk,
    output logic      capture_input_2,
    output logic      capture_input_3,
    output logic      event_input
);
    initial begin
        capture_input_2 = 1'b0;
        capture_input_3 = 1'b0;
        event_input     = 1'b0;
    end
    // Pulses span several clocks so the two-flop synchroniser cannot miss them
    task automatic pulse(input int ch, input int len);
        @(posedge ref_clk);
        if (ch == 2) capture_input_2 <= 1'b1;
        else if (ch == 3) capture_input_3 <= 1'b1;
        else event_input <= 1'b1;
        repeat (len) @(posedge ref_clk);
        capture_input_2 <= 1'b0;
        capture_input_3 <= 1'b0;
        event_input     <= 1'b0;
    endtask : pulse
endmodule : tcc_pin_model

/* File: tcc_pkg.sv */
// Types shared by the timer capture/compare block.
// Needs no include file; it uses no macros of tcc_map.svh.
package tcc_pkg;
    typedef enum logic [2:0] {
        MODE_INTERVAL, MODE_EVENT, MODE_EXT_TRIG, MODE_ONE_SHOT,
        MODE_PWM, MODE_FREE_RUN, MODE_PULSE_WIDTH
    } mode_e;
    typedef struct packed {
        logic       ccs3;
        logic       ccs2;
        logic [2:0] mode;
        logic       run;
    } ctrl_s;
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] ol;
    } ioc_s;
endpackage : tcc_pkg

/* File: timer_capture_compare_output_tb_top.sv */
// Self-checking bench of the timer capture/compare block over APB.
// Assumes tcc_pkg, tcc_block and tcc_pin_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module timer_capture_compare_output_tb_top;
    import tcc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cap2;
    logic        cap3;
    logic        evt;
    logic [3:0]  pins;
    logic [3:0]  irq;
    logic [31:0] q;
    logic [31:0] q2;
    logic        e;
    int          bad_count   = 0;
    int          comparisons = 0;

    tcc_block tcc_block_inst (.ref_clk(ref_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_2(cap2), .capture_input_3(cap3), .event_input(evt),
        .timer_out_pin(pins), .match_irq(irq));
    tcc_pin_model tcc_pin_model_inst (.ref_clk(ref_clk), .capture_input_2(cap2),
        .capture_input_3(cap3), .event_input(evt));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] ctl(input mode_e m, input logic c3, input logic r);
        return {26'h0, c3, 1'b0, m, r};
    endfunction : ctl

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        if (pready !== 1'b1) bad_count++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_irq(input int ch);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (irq[ch] !== 1'b1 && n < 300);
        `CHK(irq[ch], 1'b1)
    endtask : wait_irq

    task automatic t_reset;
        apb(0, 8'h14, 0); `CHK(q[15:0], 16'h0000)
        apb(0, 8'h18, 0); `CHK(q[15:0], 16'h0000)
        apb(0, 8'h00, 0); `CHK(q[0], 1'b0)
        `CHK(pins, 4'h0)
        apb(1, 8'h18, 32'h1234); `CHK(e, 1'b1)
        apb(0, 8'h18, 0); `CHK(q[15:0], 16'h0000)
    endtask : t_reset

    task automatic t_compare_low;
        apb(1, 8'h08, 32'h40);
        apb(1, 8'h14, 32'h5);
        apb(1, 8'h04, 32'h80);
        apb(1, 8'h00, ctl(MODE_INTERVAL, 0, 1));
        repeat (2) @(posedge ref_clk);
        `CHK(pins[3], 1'b1)
        wait_irq(3);
        @(posedge ref_clk);
        `CHK(pins[3], 1'b0)
        apb(0, 8'h18, 0); `CHK(q[15:0] > 16'h5 && q[15:0] < 16'h40, 1'b1)
        apb(1, 8'h14, 32'h30);
        apb(0, 8'h14, 0); `CHK(q[15:0], 16'h0030)
        pstrb <= 4'h1;
        apb(1, 8'h14, 32'h77); `CHK(e, 1'b1)
        pstrb <= 4'hf;
        apb(0, 8'h14, 0); `CHK(q[15:0], 16'h0030)
        apb(1, 8'h00, ctl(MODE_INTERVAL, 0, 0));
        apb(0, 8'h14, 0); `CHK(q[15:0], 16'h0030)
        apb(0, 8'h18, 0); `CHK(q[15:0], 16'h0000)
        `CHK(pins[3], 1'b0)
    endtask : t_compare_low

    task automatic t_level_high;
        apb(1, 8'h04, 32'h08);
        repeat (2) @(posedge ref_clk);
        `CHK(pins[3], 1'b1)
        apb(1, 8'h04, 32'h88);
        @(posedge ref_clk);
        `CHK(pins[3], 1'b1)
        apb(1, 8'h00, ctl(MODE_INTERVAL, 0, 1));
        repeat (2) @(posedge ref_clk);
        `CHK(pins[3], 1'b0)
        apb(1, 8'h00, ctl(MODE_INTERVAL, 0, 0));
        repeat (2) @(posedge ref_clk);
        `CHK(pins[3], 1'b1)
        apb(1, 8'h04, 32'h00);
    endtask : t_level_high

    task automatic t_capture;
        apb(1, 8'h00, ctl(MODE_FREE_RUN, 1, 1));
        repeat (20) @(posedge ref_clk);
        fork
            tcc_pin_model_inst.pulse(3, 4);
            wait_irq(3);
        join
        apb(0, 8'h14, 0);
        q2 = q;
        apb(0, 8'h18, 0); `CHK(q2[15:0] > 16'd10 && q2[15:0] < q[15:0], 1'b1)
        apb(1, 8'h00, ctl(MODE_FREE_RUN, 1, 0));
        apb(0, 8'h14, 0); `CHK(q[15:0], 16'h0000)
        // Pulse width: the capture edge also restarts the counter from zero
        apb(1, 8'h00, ctl(MODE_PULSE_WIDTH, 0, 1));
        repeat (30) @(posedge ref_clk);
        fork
            tcc_pin_model_inst.pulse(2, 4);
            wait_irq(2);
        join
        apb(0, 8'h10, 0);
        q2 = q;
        apb(0, 8'h18, 0); `CHK(q2[15:0] > 16'd20 && q[15:0] < 16'd20, 1'b1)
        apb(1, 8'h00, 0);
    endtask : t_capture

    task automatic t_batch;
        apb(1, 8'h08, 32'h10);
        apb(1, 8'h14, 32'h3);
        apb(1, 8'h00, ctl(MODE_PWM, 0, 1));
        apb(1, 8'h14, 32'h8);
        wait_irq(0);
        wait_irq(3);
        apb(0, 8'h18, 0); `CHK(q[15:0] < 16'h8, 1'b1)
        apb(1, 8'h0c, 32'h0);
        wait_irq(0);
        wait_irq(3);
        apb(0, 8'h18, 0); `CHK(q[15:0] >= 16'h8, 1'b1)
        apb(1, 8'h00, 0);
    endtask : t_batch

    task automatic wrap_up;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up

    // Whole run needs well under 2000 cycles; this only cuts a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_compare_low();
        t_level_high();
        t_capture();
        t_batch();
        wrap_up();
    end
endmodule : timer_capture_compare_output_tb_top
